// File: hdl/adv_timer_pkg.sv
// What this block does
// - Enable bit 14 gates trigger DMA request
// - Enable bit 13 gates commutation DMA request
// - Enable bits 12..9 gate channel 4..1 DMA
// - Enable bit 8 gates update DMA request
// - Enable bits 7..0 gate interrupt sources
// - Status bit 18 latches counter, self-clears
// - Bits 17,16 are channel 6,5 compare flags
// - Over-capture flags set only in input mode
// - Brake-2 flag follows active brake input 2
// - Brake flag follows active brake input
// - Trigger flag: edge, or gated start/stop
// - Commutation event sets sticky commutation flag
// - Output compare match sets flag, not center-aligned
// - Compare above reload: flag on over/underflow
// - Capture sets flag; read or write clears
// - Channels 2..4 behave like channel 1
// - Repetition counter zero sets update flag
// - Update-generate reinit also sets update flag
// - Trigger reinit also sets update flag
// - Capture while flag set sets over-capture
// - Gated mode flag tracks counter starts, stops
// - Trigger-generate bit sets trigger flag, requests
package adv_timer_pkg;

  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] ENABLE_OFFSET = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  localparam logic [7:0] EVGEN_OFFSET = 8'h14;
  localparam logic [7:0] LATCH_OFFSET = 8'h40;

  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [31:0] ENABLE_MASK = 32'h0000_7FFF;
  localparam logic [31:0] STATUS_MASK = 32'h0007_1FFF;

  // Request enable fields
  localparam int UPDATE_IRQ_EN_BIT = 0;
  localparam int CHAN_IRQ_EN_LSB = 1;
  localparam int COMM_IRQ_EN_BIT = 5;
  localparam int TRIG_IRQ_EN_BIT = 6;
  localparam int BRAKE_IRQ_EN_BIT = 7;
  localparam int UPDATE_DMA_EN_BIT = 8;
  localparam int CHAN_DMA_EN_LSB = 9;
  localparam int COMM_DMA_EN_BIT = 13;
  localparam int TRIG_DMA_EN_BIT = 14;

  // Event status fields
  localparam int UPDATE_FLAG_BIT = 0;
  localparam int CHAN_FLAG_LSB = 1;
  localparam int COMM_FLAG_BIT = 5;
  localparam int TRIG_FLAG_BIT = 6;
  localparam int BRAKE_FLAG_BIT = 7;
  localparam int BRAKE2_FLAG_BIT = 8;
  localparam int OVERCAP_FLAG_LSB = 9;
  localparam int CHAN5_FLAG_BIT = 16;
  localparam int CHAN6_FLAG_BIT = 17;
  localparam int READ_LATCH_BIT = 18;

  // Control fields
  localparam int UPDATE_DISABLE_BIT = 0;
  localparam int UPDATE_SOURCE_BIT = 1;

  // Event generation fields
  localparam int UPDATE_GEN_BIT = 0;
  localparam int CHAN_GEN_LSB = 1;
  localparam int TRIG_GEN_BIT = 6;
  localparam int BRAKE_GEN_BIT = 7;
  localparam int BRAKE2_GEN_BIT = 8;

  localparam logic [3:0] SLAVE_OFF = 4'h0;
  localparam logic [3:0] SLAVE_GATED = 4'h5;

  typedef struct packed {
    logic [31:0] enable;
    logic [31:0] status;
    logic [1:0] ctrl;
    logic [15:0] latchedCount;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] brakeMeta;
    logic [1:0] brakeSync;
    logic updateDma;
    logic [3:0] chanDma;
    logic commDma;
    logic trigDma;
    logic updateGen;
  } state_t;

endpackage : adv_timer_pkg

// File: hdl/adv_timer_event_flags.sv
`timescale 1ns/1ns
module adv_timer_event_flags
(
  input wire logic clk, // 100 MHz kernel clock
  input wire logic reset, // Async, active high
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write
  input wire logic [7:0] adr_i, // Byte address
  input wire logic [3:0] sel_i, // Byte enables
  input wire logic [31:0] dat_i, // Write data
  output logic [31:0] dat_o, // Read data
  output logic ack_o, // Wishbone ack
  input wire logic brakeIn, // Brake pin, active high
  input wire logic brake2In, // Brake 2 pin, active high
  input wire logic [3:0] slaveMode, // Slave mode select
  input wire logic trigEdge, // Valid trigger edge pulse
  input wire logic counterStartStop, // Gated start or stop pulse
  input wire logic trigReinit, // Trigger reinit pulse
  input wire logic commEvent, // Commutation update pulse
  input wire logic repZero, // Repetition counter zero pulse
  input wire logic countTick, // Counter step pulse
  input wire logic overflow, // Counter overflow pulse
  input wire logic underflow, // Counter underflow pulse
  input wire logic countDown, // Down-counting mode
  input wire logic centerAligned, // Center-aligned mode
  input wire logic [15:0] counterValue, // Live counter
  input wire logic [15:0] autoReloadValue, // Reload value
  input wire logic [5:0][15:0] compareValue, // Per-channel compare
  input wire logic [3:0] chanInputMode, // Channel 1..4 in capture
  input wire logic [3:0] chanCapture, // Capture pulses
  input wire logic [3:0] chanCaptureRead, // Capture register read pulses
  output logic irq, // Combined interrupt
  output logic updateDmaReq, // Update DMA request
  output logic [3:0] chanDmaReq, // Channel DMA requests
  output logic commDmaReq, // Commutation DMA request
  output logic trigDmaReq, // Trigger DMA request
  output logic updateGenPulse // Counter reinit to core
);
  import adv_timer_pkg::*;

  state_t state_reg;
  state_t state_next;

  logic access;
  logic wrTake;
  logic wrStatus;
  logic [31:0] wmask;
  logic [31:0] gen;
  logic [31:0] stClr;
  logic [31:0] setMask;
  logic [31:0] readClr;
  logic [31:0] irqMask;
  logic updateSet;
  logic trigSet;
  logic [5:0] cmpHit;
  logic [5:0] chanSet;
  logic [3:0] capEvt;
  logic [3:0] overSet;

  assign access = cyc_i && stb_i;
  // Write commits on the edge where the master sees ack
  assign wrTake = access && we_i && state_reg.ack;
  assign wrStatus = wrTake && (adr_i == STATUS_OFFSET);
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign gen = (wrTake && adr_i == EVGEN_OFFSET) ? (dat_i & wmask) : 32'h0000_0000;

  genvar c;
  generate
    for (c = 0; c < 6; c++)
    begin : chanGen
      // Above reload the equality never happens, so wrap events stand in
      assign cmpHit[c] = (compareValue[c] > autoReloadValue)
        ? ((overflow && !countDown) || (underflow && countDown))
        : (countTick && counterValue == compareValue[c] && !centerAligned);
      if (c < 4)
      begin : capGen
        assign capEvt[c] = chanInputMode[c] && (chanCapture[c] || gen[CHAN_GEN_LSB + c]);
        assign chanSet[c] = chanInputMode[c] ? capEvt[c]
          : (cmpHit[c] || gen[CHAN_GEN_LSB + c]);
        assign overSet[c] = capEvt[c] && state_reg.status[CHAN_FLAG_LSB + c];
      end
      else
      begin : outGen
        assign chanSet[c] = cmpHit[c];
      end
    end
  endgenerate

  always_comb
  begin
    state_next = state_reg;
    state_next.brakeMeta = {brake2In, brakeIn};
    state_next.brakeSync = state_reg.brakeMeta;

    state_next.ack = access && !state_reg.ack;
    state_next.rdata = 32'h0000_0000;
    if (access && !we_i && !state_reg.ack)
    begin
      case (adr_i)
        CTRL_OFFSET: state_next.rdata = {30'h0000_0000, state_reg.ctrl};
        ENABLE_OFFSET: state_next.rdata = state_reg.enable;
        STATUS_OFFSET: state_next.rdata = state_reg.status;
        LATCH_OFFSET: state_next.rdata = {16'h0000, state_reg.latchedCount};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end

    if (wrTake && adr_i == CTRL_OFFSET)
    begin
      state_next.ctrl = (state_reg.ctrl & ~wmask[1:0]) | (dat_i[1:0] & wmask[1:0]);
    end
    if (wrTake && adr_i == ENABLE_OFFSET)
    begin
      state_next.enable = ((state_reg.enable & ~wmask) | (dat_i & wmask)) & ENABLE_MASK;
    end

    // Writing 1 leaves a flag alone, only a 0 clears
    stClr = wrStatus ? (wmask & ~dat_i) : 32'h0000_0000;
    stClr[READ_LATCH_BIT] = 1'b0;
    readClr = 32'h0000_0000;
    readClr[CHAN_FLAG_LSB +: 4] = chanInputMode & chanCaptureRead;

    updateSet = !state_reg.ctrl[UPDATE_DISABLE_BIT] && (repZero
      || (!state_reg.ctrl[UPDATE_SOURCE_BIT]
      && (gen[UPDATE_GEN_BIT] || trigReinit)));
    if (slaveMode == SLAVE_GATED)
    begin
      trigSet = counterStartStop || gen[TRIG_GEN_BIT];
    end
    else
    begin
      trigSet = (slaveMode != SLAVE_OFF && trigEdge) || gen[TRIG_GEN_BIT];
    end

    setMask = 32'h0000_0000;
    setMask[UPDATE_FLAG_BIT] = updateSet;
    setMask[CHAN_FLAG_LSB +: 4] = chanSet[3:0];
    setMask[COMM_FLAG_BIT] = commEvent;
    setMask[TRIG_FLAG_BIT] = trigSet;
    // Level set keeps the flag up while the input stays active
    setMask[BRAKE_FLAG_BIT] = state_reg.brakeSync[0] || gen[BRAKE_GEN_BIT];
    setMask[BRAKE2_FLAG_BIT] = state_reg.brakeSync[1] || gen[BRAKE2_GEN_BIT];
    setMask[OVERCAP_FLAG_LSB +: 4] = overSet;
    setMask[CHAN5_FLAG_BIT] = chanSet[4];
    setMask[CHAN6_FLAG_BIT] = chanSet[5];

    // Set wins over any clear in the same cycle
    state_next.status = ((state_reg.status & ~stClr & ~readClr) | setMask) & STATUS_MASK;

    // Latch takes one cycle, then hardware drops the request
    if (state_reg.status[READ_LATCH_BIT])
    begin
      state_next.latchedCount = counterValue;
      state_next.status[READ_LATCH_BIT] = 1'b0;
    end
    if (wrStatus && wmask[READ_LATCH_BIT])
    begin
      state_next.status[READ_LATCH_BIT] = dat_i[READ_LATCH_BIT];
    end

    state_next.updateDma = updateSet && state_reg.enable[UPDATE_DMA_EN_BIT];
    state_next.chanDma = chanSet[3:0] & state_reg.enable[CHAN_DMA_EN_LSB +: 4];
    state_next.commDma = commEvent && state_reg.enable[COMM_DMA_EN_BIT];
    state_next.trigDma = trigSet && state_reg.enable[TRIG_DMA_EN_BIT];
    state_next.updateGen = gen[UPDATE_GEN_BIT];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= '0;
      state_reg.enable <= ENABLE_RESET;
      state_reg.status <= STATUS_RESET;
      state_reg.ctrl <= CTRL_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  always_comb
  begin
    irqMask = 32'h0000_0000;
    irqMask[UPDATE_FLAG_BIT] = state_reg.enable[UPDATE_IRQ_EN_BIT];
    irqMask[CHAN_FLAG_LSB +: 4] = state_reg.enable[CHAN_IRQ_EN_LSB +: 4];
    irqMask[COMM_FLAG_BIT] = state_reg.enable[COMM_IRQ_EN_BIT];
    irqMask[TRIG_FLAG_BIT] = state_reg.enable[TRIG_IRQ_EN_BIT];
    // One brake enable serves both brake flags
    irqMask[BRAKE_FLAG_BIT] = state_reg.enable[BRAKE_IRQ_EN_BIT];
    irqMask[BRAKE2_FLAG_BIT] = state_reg.enable[BRAKE_IRQ_EN_BIT];
  end

  assign irq = |(state_reg.status & irqMask);
  assign dat_o = state_reg.rdata;
  assign ack_o = state_reg.ack;
  assign updateDmaReq = state_reg.updateDma;
  assign chanDmaReq = state_reg.chanDma;
  assign commDmaReq = state_reg.commDma;
  assign trigDmaReq = state_reg.trigDma;
  assign updateGenPulse = state_reg.updateGen;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence latchRequest;
    state_reg.status[READ_LATCH_BIT] && !wrStatus;
  endsequence

  sequence latchDone;
    !state_reg.status[READ_LATCH_BIT] && state_reg.latchedCount == $past(counterValue);
  endsequence

  sequence captureWhileSet;
    chanInputMode[0] && chanCapture[0] && state_reg.status[CHAN_FLAG_LSB];
  endsequence

  trig_dma_gate_a: assert property (trigDmaReq |-> $past(state_reg.enable[TRIG_DMA_EN_BIT]))
    else $error("trigger DMA request without its enable");
  comm_dma_gate_a: assert property (
    commEvent && state_reg.enable[COMM_DMA_EN_BIT] |=> commDmaReq)
    else $error("commutation DMA request missing");
  chan_dma_gate_a: assert property (
    chanDmaReq[0] |-> $past(state_reg.enable[CHAN_DMA_EN_LSB]))
    else $error("channel 1 DMA request without its enable");
  update_dma_off_a: assert property (
    !state_reg.enable[UPDATE_DMA_EN_BIT] |=> !updateDmaReq)
    else $error("update DMA request while disabled");
  irq_update_a: assert property (
    state_reg.status[UPDATE_FLAG_BIT] && state_reg.enable[UPDATE_IRQ_EN_BIT] |-> irq)
    else $error("enabled update flag without interrupt");
  irq_quiet_a: assert property ((state_reg.enable[7:0] == 8'h00) |-> !irq)
    else $error("interrupt with all enables off");
  read_latch_a: assert property (latchRequest |=> latchDone)
    else $error("counter latch not taken or flag not cleared");
  overcap_set_a: assert property (captureWhileSet |=> state_reg.status[OVERCAP_FLAG_LSB])
    else $error("over-capture not flagged");
  overcap_mode_a: assert property (
    $rose(state_reg.status[OVERCAP_FLAG_LSB]) |-> $past(chanInputMode[0]))
    else $error("over-capture set outside input mode");
  brake_hold_a: assert property (state_reg.brakeSync[0] |=> state_reg.status[BRAKE_FLAG_BIT])
    else $error("brake flag cleared while brake active");
  brake2_hold_a: assert property (
    state_reg.brakeSync[1] |=> state_reg.status[BRAKE2_FLAG_BIT])
    else $error("brake 2 flag cleared while input active");
  trig_gated_a: assert property (
    slaveMode == SLAVE_GATED && counterStartStop |=> state_reg.status[TRIG_FLAG_BIT])
    else $error("gated start or stop did not set trigger flag");
  comm_flag_a: assert property (commEvent |=> state_reg.status[COMM_FLAG_BIT])
    else $error("commutation flag not set");
  update_flag_a: assert property (
    repZero && !state_reg.ctrl[UPDATE_DISABLE_BIT] |=> state_reg.status[UPDATE_FLAG_BIT])
    else $error("update flag not set on repetition zero");
  update_blocked_a: assert property (
    gen[UPDATE_GEN_BIT] && state_reg.ctrl[UPDATE_SOURCE_BIT] && !repZero
    && !state_reg.status[UPDATE_FLAG_BIT] |=> !state_reg.status[UPDATE_FLAG_BIT])
    else $error("update flag set though source restricted");
  set_wins_a: assert property (chanSet[0] && chanCaptureRead[0] |=> state_reg.status[CHAN_FLAG_LSB])
    else $error("clear beat a simultaneous set");
  reserved_zero_a: assert property (
    (state_reg.status & ~STATUS_MASK) == 32'h0000_0000
    && (state_reg.enable & ~ENABLE_MASK) == 32'h0000_0000)
    else $error("reserved bit set");
  ack_single_a: assert property (ack_o |=> !ack_o)
    else $error("ack held for two cycles");

endmodule : adv_timer_event_flags

// File: tb/dma_irq_sink.sv
`timescale 1ns/1ns
module dma_irq_sink
(
  input wire logic clk, // Kernel clock
  input wire logic reset, // Async, active high
  input wire logic clear, // Forget requests seen so far
  input wire logic [6:0] req, // Trigger, comm, chan 4..1, update
  output logic [6:0] seen // Requests taken since clear
);
  // Sticky, so a one-cycle request is never lost between bench samples
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      seen <= 7'h00;
    else if (clear)
      seen <= 7'h00;
    else
      seen <= seen | req;
  end
endmodule : dma_irq_sink

// File: tb/test_adv_timer_event_flags.sv
`timescale 1ns/1ns
`define CHK(act, exp) \
  begin \
    numChecks++; \
    if ((act) !== (exp)) \
    begin \
      errTotal++; \
      $display("mismatch %0t got %h want %h", $time, act, exp); \
    end \
  end
module test_adv_timer_event_flags;
  import adv_timer_pkg::*;
  logic clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, mask, expV;
  logic brakeIn = 1'b0, brake2In = 1'b0, trigEdge = 1'b0, startStop = 1'b0;
  logic commEvent = 1'b0, repZero = 1'b0, countTick = 1'b0, sinkClear = 1'b0;
  logic trigReinit = 1'b0;
  logic [3:0] capRead = 4'h0;
  logic [3:0] slaveMode = 4'h0, inMode = 4'h0, capture = 4'h0, chanDma;
  logic [15:0] cv = 16'h0, counterValue = 16'h0, reload = 16'h0;
  logic [5:0][15:0] compareValue = '0;
  logic updDma, commDma, trigDma;
  logic [6:0] seen;
  logic [31:0] expQ[$];
  int errTotal = 0;
  int numChecks = 0;

  adv_timer_event_flags i_dut (.clk(clk), .reset(reset), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .brakeIn(brakeIn), .brake2In(brake2In), .slaveMode(slaveMode), .trigEdge(trigEdge),
    .counterStartStop(startStop), .trigReinit(trigReinit), .commEvent(commEvent),
    .repZero(repZero), .countTick(countTick), .overflow(1'b0), .underflow(1'b0),
    .countDown(1'b0), .centerAligned(1'b0), .counterValue(counterValue),
    .autoReloadValue(reload), .compareValue(compareValue), .chanInputMode(inMode),
    .chanCapture(capture), .chanCaptureRead(capRead), .irq(irq), .updateDmaReq(updDma),
    .chanDmaReq(chanDma), .commDmaReq(commDma), .trigDmaReq(trigDma), .updateGenPulse());

  dma_irq_sink i_sink (.clk(clk), .reset(reset), .clear(sinkClear),
    .req({trigDma, commDma, chanDma, updDma}), .seen(seen));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // Reads note their expected word; this process checks it when ack arrives
  always @(posedge clk)
  begin
    if (ack === 1'b1 && we === 1'b0)
    begin
      expV = expQ.pop_front();
      `CHK(rdat, expV)
    end
  end

  // Classic cycle; for a read, d is the expected word
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    if (!w)
      expQ.push_back(d);
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // ev: countTick, startStop, trigEdge, commEvent, repZero, capture[3:0]
  task automatic fire(input logic [8:0] ev);
    @(posedge clk);
    {countTick, startStop, trigEdge, commEvent, repZero, capture} <= ev;
    sinkClear <= 1'b1;
    @(posedge clk);
    {countTick, startStop, trigEdge, commEvent, repZero, capture} <= 9'h000;
    sinkClear <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : fire

  task automatic complete_run;
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // Under two hundred cycles are needed; this is generous
  initial
  begin
    repeat (5000) @(posedge clk);
    errTotal++;
    complete_run;
  end

  initial
  begin
    void'($urandom(16));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    wb(1'b0, STATUS_OFFSET, STATUS_RESET);
    wb(1'b0, ENABLE_OFFSET, ENABLE_RESET);
    wb(1'b1, ENABLE_OFFSET, 32'hFFFF_FFFF);
    wb(1'b0, ENABLE_OFFSET, 32'h0000_7FFF);
    wb(1'b0, 8'h20, 32'h0);
    inMode <= 4'hF;
    slaveMode <= 4'h6;
    for (int i = 0; i < 5; i++)
    begin
      mask = (i == 0) ? 32'h0 : (i == 1) ? 32'h7FFF : ($urandom & 32'h7FFF);
      wb(1'b1, ENABLE_OFFSET, mask);
      fire(9'h07F);
      `CHK(seen, mask[14:8])
      `CHK(irq, |mask[6:0])
      wb(1'b0, STATUS_OFFSET, (i == 0) ? 32'h7F : 32'h1E7F);
    end
    wb(1'b1, STATUS_OFFSET, 32'h0003_FFFF);
    wb(1'b0, STATUS_OFFSET, 32'h1E7F);
    wb(1'b1, STATUS_OFFSET, 32'h0);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    wb(1'b1, ENABLE_OFFSET, 32'h80);
    brakeIn <= 1'b1;
    brake2In <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(irq, 1'b1)
    wb(1'b1, STATUS_OFFSET, 32'h0);
    wb(1'b0, STATUS_OFFSET, 32'h180);
    brakeIn <= 1'b0;
    brake2In <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b1, STATUS_OFFSET, 32'h0);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    `CHK(irq, 1'b0)
    cv = 16'($urandom);
    counterValue <= cv;
    wb(1'b1, STATUS_OFFSET, 32'h0004_0000);
    wb(1'b0, LATCH_OFFSET, {16'h0, cv});
    wb(1'b0, STATUS_OFFSET, 32'h0);
    inMode <= 4'h0;
    slaveMode <= SLAVE_GATED;
    compareValue <= {6{cv}};
    reload <= 16'hFFFF;
    fire(9'h140);
    wb(1'b0, STATUS_OFFSET, 32'h0003_001E);
    fire(9'h080);
    wb(1'b0, STATUS_OFFSET, 32'h0003_005E);
    wb(1'b1, STATUS_OFFSET, 32'h0);
    wb(1'b1, EVGEN_OFFSET, 32'h40);
    wb(1'b0, STATUS_OFFSET, 32'h40);
    wb(1'b1, STATUS_OFFSET, 32'h0);
    inMode <= 4'h1;
    fire(9'h001);
    @(posedge clk);
    trigReinit <= 1'b1;
    @(posedge clk);
    trigReinit <= 1'b0;
    wb(1'b0, STATUS_OFFSET, 32'h3);
    capRead <= 4'h1;
    @(posedge clk);
    capRead <= 4'h0;
    wb(1'b0, STATUS_OFFSET, 32'h1);
    complete_run;
  end
endmodule : test_adv_timer_event_flags
